// File: common/scl_pkg.sv
// Behaviour
// - Enable bit gates checksum on reads
// - Both checksums use polynomial 0x8005
// - Static read: checksum after every register
// - Incremental read: checksum after address 0xF
// - First checksum covers status byte too
// - Format bit picks 16 or 32-bit output
// - Key 0xA5 at 0xD unlocks writes
// - Key resets to 0xA5, map unlocked
// - Locked: only key address accepts writes
// - Config checksum over 0x1..0xF, field 0xF
// - Checksum only while locked, else zero
// - Status bits forced one, field zero
// - First checksum in 11 clocks, kept reference
// - Recompute every 11 clocks and compare
// - Mismatch raises flag, register and pin
// - Unlock clears pin; flags clear on read
// - Error forces pin low in bitstream mode
// - No error at power-up until locked
// - Status bit 1 carries checksum error
// - Conversion start command clears error
package scl_pkg;

    // ----------------------------------------------------------------
    // Checksum and key constants
    // ----------------------------------------------------------------
    localparam int          CRC_W      = 16;
    localparam logic [15:0] CRC_POLY   = 16'h8005;
    localparam logic [15:0] CRC_INIT   = 16'h0000;
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  ADDR_KEY   = 4'hd;
    localparam logic [3:0]  ADDR_LAST  = 4'hf;
    localparam int          KEY_W      = 8;
    localparam logic [7:0]  KEY_UNLOCK = 8'ha5;

    // ----------------------------------------------------------------
    // Map image and check timing
    // ----------------------------------------------------------------
    localparam int          CFG_PERIOD = 11;
    localparam int          SLOT_W     = 4;
    localparam logic [3:0]  SLOT_FIRST = 4'h0;
    localparam logic [3:0]  SLOT_LAST  = 4'(CFG_PERIOD - 1);
    localparam int          IMG_HI_W   = 176;
    localparam int          IMG_E_W    = 16;
    localparam int          IMG_W      = IMG_HI_W + IMG_E_W;
    localparam int          MSG_W      = IMG_W + KEY_W + CRC_W;
    localparam int          CHUNK      = (MSG_W + CFG_PERIOD - 1) / CFG_PERIOD;
    localparam int          MSG_PAD_W  = CHUNK * CFG_PERIOD;
    localparam int          IRQ_STAT_LSB = 156;
    localparam logic [IMG_W-1:0] IRQ_STAT_MASK = IMG_W'(3'h7) << IRQ_STAT_LSB;

    // ----------------------------------------------------------------
    // Read side framing
    // ----------------------------------------------------------------
    localparam int          STAT_W       = 3;
    localparam int          STAT_POR_BIT = 0;
    localparam int          STAT_CRC_BIT = 1;
    localparam int          STAT_DR_BIT  = 2;
    localparam int          CNT_W        = 6;
    localparam logic [5:0]  CNT_SHORT    = 6'h0f;
    localparam logic [5:0]  CNT_LONG     = 6'h1f;
    localparam int          SR_W         = 32;

    typedef enum logic [1:0] {
        SCL_ST_UNLOCKED = 2'h0,
        SCL_ST_FIRST    = 2'h1,
        SCL_ST_RUN      = 2'h3
    } scl_cfg_state_t;

    typedef struct packed {
        logic              start;
        logic              bit_valid;
        logic              bit_val;
        logic              reg_done;
        logic              static_mode;
        logic [ADDR_W-1:0] addr;
    } scl_rd_evt_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [KEY_W-1:0]  data;
    } scl_wr_req_t;

    function automatic logic [15:0] scl_crc_bit(input logic [15:0] crc, input logic b);
        logic fb;
        fb = crc[15] ^ b;
        return {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    endfunction

endpackage

// File: core/scl_core.sv
`timescale 1ns/1ps
module scl_core (
    input  wire logic                            mclk_i,
    input  wire logic                            rst_n_i,
    input  wire logic                            ce_i,
    input  wire scl_pkg::scl_wr_req_t            wr_req_i,
    output logic                                 wr_accept_o,
    input  wire logic [scl_pkg::IMG_W-1:0]       cfg_image_i,
    input  wire logic                            conv_start_i,
    input  wire logic                            irq_reg_read_i,
    input  wire logic                            irq_pin_src_i,
    input  wire logic                            read_crc_enable_i,
    input  wire logic                            crc_format_i,
    output logic [scl_pkg::KEY_W-1:0]            write_lock_key_o,
    output logic [scl_pkg::CRC_W-1:0]            config_map_checksum_o,
    output logic                                 config_crc_error_flag_o,
    output logic                                 irq_n_o,
    input  wire logic                            sck_i,
    input  wire scl_pkg::scl_rd_evt_t            rd_evt_i,
    input  wire logic                            crc_shift_i,
    input  wire logic                            status_done_i,
    input  wire logic                            data_ready_flag_i,
    input  wire logic                            por_flag_i,
    output logic [scl_pkg::STAT_W-1:0]           status_bits_o,
    output logic                                 crc_insert_o,
    output logic                                 crc_bit_o,
    output logic [scl_pkg::CRC_W-1:0]            cfg_crc_sck_o
);

    // ----------------------------------------------------------------
    // Core clock declarations
    // ----------------------------------------------------------------
    logic [scl_pkg::KEY_W-1:0]     key_reg;
    logic                          locked;
    logic                          locked_next;
    logic                          key_hit;
    scl_pkg::scl_cfg_state_t       state_reg;
    logic [scl_pkg::SLOT_W-1:0]    slot_reg;
    logic [scl_pkg::CRC_W-1:0]     acc_reg;
    logic [scl_pkg::CRC_W-1:0]     acc_next;
    logic [scl_pkg::CRC_W-1:0]     ref_reg;
    logic [scl_pkg::CRC_W-1:0]     cfg_crc_reg;
    logic [scl_pkg::MSG_PAD_W-1:0] msg_reg;
    logic [scl_pkg::MSG_PAD_W-1:0] msg_full;
    logic [scl_pkg::IMG_W-1:0]     img_mod;
    logic [scl_pkg::CHUNK-1:0]     chunk;
    logic                          err_reg;
    logic                          err_set;
    logic                          irq_flag_reg;
    logic                          irq_n_reg;
    logic [scl_pkg::CRC_W-1:0]     xfer_data_reg;
    logic                          xfer_req_reg;
    logic                          ack_s1_reg;
    logic                          ack_s2_reg;
    logic                          ack_sck_reg;

    function automatic logic [15:0] crc_chunk(input logic [15:0] crc,
                                              input logic [scl_pkg::CHUNK-1:0] d);
        logic [15:0] c;
        c = crc;
        for (int i = scl_pkg::CHUNK - 1; i >= 0; i--) begin
            c = scl_pkg::scl_crc_bit(c, d[i]);
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Write lock key
    // ----------------------------------------------------------------
    assign key_hit     = wr_req_i.valid && (wr_req_i.addr == scl_pkg::ADDR_KEY);
    assign locked      = (key_reg != scl_pkg::KEY_UNLOCK);
    assign locked_next = key_hit ? (wr_req_i.data != scl_pkg::KEY_UNLOCK) : locked;

    assign wr_accept_o = wr_req_i.valid && (!locked || key_hit);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            key_reg <= scl_pkg::KEY_UNLOCK;
        end else if (ce_i && key_hit) begin
            key_reg <= wr_req_i.data;
        end
    end

    // ----------------------------------------------------------------
    // Map checksum message
    // ----------------------------------------------------------------
    // status bits forced
    assign img_mod  = cfg_image_i | scl_pkg::IRQ_STAT_MASK;
    assign msg_full = scl_pkg::MSG_PAD_W'({img_mod[scl_pkg::IMG_W-1:scl_pkg::IMG_E_W], key_reg,
                                           img_mod[scl_pkg::IMG_E_W-1:0], scl_pkg::CRC_INIT});
    // Leading pad zeros leave a zero-seeded checksum unchanged
    assign chunk    = (slot_reg == scl_pkg::SLOT_FIRST)
                    ? msg_full[scl_pkg::MSG_PAD_W-1 -: scl_pkg::CHUNK]
                    : msg_reg[scl_pkg::MSG_PAD_W-1 -: scl_pkg::CHUNK];
    assign acc_next = crc_chunk((slot_reg == scl_pkg::SLOT_FIRST) ? scl_pkg::CRC_INIT : acc_reg,
                                chunk);
    assign err_set  = (state_reg == scl_pkg::SCL_ST_RUN) && (slot_reg == scl_pkg::SLOT_LAST)
                    && (acc_next != ref_reg);

    // ----------------------------------------------------------------
    // Map checksum sequencer
    // ----------------------------------------------------------------
    // lock driven sequencing
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg   <= scl_pkg::SCL_ST_UNLOCKED;
            slot_reg    <= scl_pkg::SLOT_FIRST;
            acc_reg     <= scl_pkg::CRC_INIT;
            ref_reg     <= scl_pkg::CRC_INIT;
            cfg_crc_reg <= scl_pkg::CRC_INIT;
            msg_reg     <= '0;
        end else if (ce_i) begin
            case (state_reg)
                scl_pkg::SCL_ST_UNLOCKED: begin
                    slot_reg    <= scl_pkg::SLOT_FIRST;
                    cfg_crc_reg <= scl_pkg::CRC_INIT;
                    ref_reg     <= scl_pkg::CRC_INIT;
                    if (locked_next) begin
                        state_reg <= scl_pkg::SCL_ST_FIRST;
                    end
                end
                scl_pkg::SCL_ST_FIRST, scl_pkg::SCL_ST_RUN: begin
                    acc_reg <= acc_next;
                    if (slot_reg == scl_pkg::SLOT_FIRST) begin
                        msg_reg <= msg_full << scl_pkg::CHUNK;
                    end else begin
                        msg_reg <= msg_reg << scl_pkg::CHUNK;
                    end
                    if (slot_reg == scl_pkg::SLOT_LAST) begin
                        slot_reg    <= scl_pkg::SLOT_FIRST;
                        cfg_crc_reg <= acc_next;
                        if (state_reg == scl_pkg::SCL_ST_FIRST) begin
                            ref_reg   <= acc_next;
                            state_reg <= scl_pkg::SCL_ST_RUN;
                        end
                    end else begin
                        slot_reg <= slot_reg + 4'h1;
                    end
                    if (!locked_next) begin
                        state_reg   <= scl_pkg::SCL_ST_UNLOCKED;
                        cfg_crc_reg <= scl_pkg::CRC_INIT;
                    end
                end
                default: begin
                    state_reg <= scl_pkg::SCL_ST_UNLOCKED;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Error flag, interrupt register bit and pin
    // ----------------------------------------------------------------
    // error latch, set wins over start, unlock clear wins over set
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            err_reg <= 1'b0;
        end else if (ce_i) begin
            if (!locked_next) begin
                err_reg <= 1'b0;
            end else if (err_set) begin
                err_reg <= 1'b1;
            end else if (conv_start_i) begin
                err_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (err_reg) begin
                irq_flag_reg <= 1'b1;
            end else if (irq_reg_read_i) begin
                irq_flag_reg <= 1'b0;
            end
        end
    end

    // pin forced low, even over bitstream
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_n_reg <= 1'b1;
        end else if (ce_i) begin
            irq_n_reg <= err_reg ? 1'b0 : irq_pin_src_i;
        end
    end

    assign write_lock_key_o        = key_reg;
    assign config_map_checksum_o   = cfg_crc_reg;
    assign config_crc_error_flag_o = irq_flag_reg;
    assign irq_n_o                 = irq_n_reg;

    // ----------------------------------------------------------------
    // Checksum field hand-off to serial clock
    // ----------------------------------------------------------------
    // Data only moves while request and acknowledge agree, so it is stable when sampled
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            xfer_data_reg <= scl_pkg::CRC_INIT;
            xfer_req_reg  <= 1'b0;
            ack_s1_reg    <= 1'b0;
            ack_s2_reg    <= 1'b0;
        end else if (ce_i) begin
            ack_s1_reg <= ack_sck_reg;
            ack_s2_reg <= ack_s1_reg;
            if ((xfer_req_reg == ack_s2_reg) && (xfer_data_reg != cfg_crc_reg)) begin
                xfer_data_reg <= cfg_crc_reg;
                xfer_req_reg  <= ~xfer_req_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial clock side
    // ----------------------------------------------------------------
    logic                          rst_s1_reg;
    logic                          rst_s2_reg;
    logic                          ce_s1_reg;
    logic                          ce_s2_reg;
    logic                          en_s1_reg;
    logic                          en_s2_reg;
    logic                          fmt_s1_reg;
    logic                          fmt_s2_reg;
    logic                          err_s1_reg;
    logic                          err_s2_reg;
    logic                          req_s1_reg;
    logic                          req_s2_reg;
    logic [scl_pkg::CRC_W-1:0]     cfg_sck_reg;
    logic                          stat_crc_reg;
    logic [scl_pkg::STAT_W-1:0]    stat_reg;
    logic [scl_pkg::CRC_W-1:0]     rd_crc_reg;
    logic [scl_pkg::CRC_W-1:0]     rd_crc_next;
    logic [scl_pkg::SR_W-1:0]      sr_reg;
    logic [scl_pkg::CNT_W-1:0]     cnt_reg;
    logic                          emit_reg;
    logic                          trig;
    logic                          sck_run;

    always_ff @(posedge sck_i) begin
        rst_s1_reg <= rst_n_i;
        rst_s2_reg <= rst_s1_reg;
        ce_s1_reg  <= ce_i;
        ce_s2_reg  <= ce_s1_reg;
        en_s1_reg  <= read_crc_enable_i;
        en_s2_reg  <= en_s1_reg;
        fmt_s1_reg <= crc_format_i;
        fmt_s2_reg <= fmt_s1_reg;
        err_s1_reg <= err_reg;
        err_s2_reg <= err_s1_reg;
        req_s1_reg <= xfer_req_reg;
        req_s2_reg <= req_s1_reg;
    end

    assign sck_run = rst_s2_reg && ce_s2_reg;

    always_ff @(posedge sck_i) begin
        if (!rst_s2_reg) begin
            ack_sck_reg <= 1'b0;
            cfg_sck_reg <= scl_pkg::CRC_INIT;
        end else if (ce_s2_reg && (req_s2_reg != ack_sck_reg)) begin
            cfg_sck_reg <= xfer_data_reg;
            ack_sck_reg <= req_s2_reg;
        end
    end

    always_ff @(posedge sck_i) begin
        if (!rst_s2_reg) begin
            stat_crc_reg <= 1'b0;
            stat_reg     <= '0;
        end else if (ce_s2_reg) begin
            if (err_s2_reg) begin
                stat_crc_reg <= 1'b1;
            end else if (status_done_i) begin
                stat_crc_reg <= 1'b0;
            end
            stat_reg[scl_pkg::STAT_DR_BIT]  <= data_ready_flag_i;
            stat_reg[scl_pkg::STAT_CRC_BIT] <= stat_crc_reg;
            stat_reg[scl_pkg::STAT_POR_BIT] <= por_flag_i;
        end
    end

    assign rd_crc_next = (rd_evt_i.bit_valid && !emit_reg)
                       ? scl_pkg::scl_crc_bit(rd_crc_reg, rd_evt_i.bit_val) : rd_crc_reg;
    assign trig = rd_evt_i.reg_done && en_s2_reg && !emit_reg
                && (rd_evt_i.static_mode || (rd_evt_i.addr == scl_pkg::ADDR_LAST));

    // status byte lands in the first message
    always_ff @(posedge sck_i) begin
        if (!rst_s2_reg) begin
            rd_crc_reg <= scl_pkg::CRC_INIT;
        end else if (ce_s2_reg) begin
            if (rd_evt_i.start || trig) begin
                rd_crc_reg <= scl_pkg::CRC_INIT;
            end else begin
                rd_crc_reg <= rd_crc_next;
            end
        end
    end

    always_ff @(posedge sck_i) begin
        if (!rst_s2_reg) begin
            emit_reg <= 1'b0;
            sr_reg   <= '0;
            cnt_reg  <= '0;
        end else if (ce_s2_reg) begin
            if (rd_evt_i.start) begin
                emit_reg <= 1'b0;
            end else if (trig) begin
                emit_reg <= 1'b1;
                sr_reg   <= {rd_crc_next, scl_pkg::CRC_INIT};
                cnt_reg  <= '0;
            end else if (emit_reg && crc_shift_i) begin
                sr_reg  <= sr_reg << 1;
                cnt_reg <= cnt_reg + 6'h1;
                if (cnt_reg == (fmt_s2_reg ? scl_pkg::CNT_LONG : scl_pkg::CNT_SHORT)) begin
                    emit_reg <= 1'b0;
                end
            end
        end
    end

    assign crc_insert_o  = emit_reg;
    assign crc_bit_o     = sr_reg[scl_pkg::SR_W-1];
    assign status_bits_o = stat_reg;
    assign cfg_crc_sck_o = cfg_sck_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence lock_taken;
        $rose(locked) ##0 (state_reg == scl_pkg::SCL_ST_FIRST);
    endsequence

    sequence first_done;
        ##[1:11] (state_reg == scl_pkg::SCL_ST_RUN);
    endsequence

    chk_key_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> (key_reg == scl_pkg::KEY_UNLOCK && !err_reg && irq_n_o))
        else $error("Key not unlocked after reset");

    chk_write_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_req_i.valid && locked && wr_req_i.addr != scl_pkg::ADDR_KEY) |-> !wr_accept_o)
        else $error("Write accepted while locked");

    chk_unlock_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!locked && ce_i) |=> (cfg_crc_reg == scl_pkg::CRC_INIT))
        else $error("Checksum field not zero while unlocked");

    chk_first_ref: assert property (@(posedge mclk_i) disable iff (!rst_n_i || !ce_i || !locked)
        lock_taken |-> first_done)
        else $error("First checksum late");

    chk_period_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i || !ce_i || !locked)
        (state_reg == scl_pkg::SCL_ST_RUN && slot_reg == scl_pkg::SLOT_FIRST)
        |-> ##10 (slot_reg == scl_pkg::SLOT_LAST))
        else $error("Check period not eleven clocks");

    chk_err_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (err_reg && ce_i && locked_next && !conv_start_i) |=> err_reg)
        else $error("Error dropped while locked");

    chk_pin_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (err_reg && ce_i) |=> !irq_n_o)
        else $error("Pin not low on error");

    chk_unlock_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && $fell(locked)) |-> (!err_reg ##1 (irq_n_o == $past(irq_pin_src_i))))
        else $error("Unlock did not clear pin");

    chk_mismatch_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (err_set && ce_i && locked_next) |=> (err_reg ##1 irq_flag_reg))
        else $error("Mismatch not flagged");

    chk_crc_off: assert property (@(posedge sck_i) disable iff (!rst_s2_reg)
        (!en_s2_reg && !emit_reg && !rd_evt_i.start) |=> !emit_reg)
        else $error("Checksum inserted while disabled");

    chk_static_crc: assert property (@(posedge sck_i) disable iff (!sck_run)
        (trig && !rd_evt_i.start) |=> (emit_reg && sr_reg[scl_pkg::SR_W-1] == $past(rd_crc_next[15])))
        else $error("Checksum not started after register");

    chk_crc_len: assert property (@(posedge sck_i) disable iff (!sck_run)
        (emit_reg && crc_shift_i && !rd_evt_i.start && !fmt_s2_reg
         && cnt_reg == scl_pkg::CNT_SHORT) |=> !emit_reg)
        else $error("Short checksum frame length wrong");

endmodule

// File: sim/scl_host_model.sv
`timescale 1ns/1ps
module scl_host_model (
    output logic                 sck_o,
    output scl_pkg::scl_rd_evt_t evt_o,
    output logic                 shift_o,
    output logic                 done_o,
    input  wire logic            insert_i,
    input  wire logic            bit_i
);
    logic       md;
    logic [3:0] adr;
    initial begin
        sck_o = 1'b0;
        evt_o = '0;
        shift_o = 1'b0;
        done_o = 1'b0;
        md = 1'b0;
        adr = 4'h0;
    end
    function automatic logic [15:0] step(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h8005 : 16'h0000);
    endfunction
    // Link clock only runs inside these calls and rests low between frames
    task automatic cyc(input logic st, v, b, rd, sh, dn);
        evt_o = {st, v, b, rd, md, adr};
        shift_o = sh;
        done_o = dn;
        #7.5 sck_o = 1'b1;
        #7.5 sck_o = 1'b0;
    endtask
    // residue over sent and received bits
    task automatic frame(input logic sm, input logic [3:0] ad, input logic [15:0] d,
                         output int n, output logic [15:0] r);
        logic [15:0] c;
        c = 16'h0000;
        n = 0;
        md = sm;
        adr = ad;
        repeat (3) cyc(0, 0, 0, 0, 0, 0);
        cyc(1, 0, 0, 0, 0, 0);
        for (int i = 15; i >= 0; i--) begin
            c = step(c, d[i]);
            cyc(0, 1, d[i], i == 0, 0, i == 8);
        end
        repeat (40) begin
            if (insert_i === 1'b1) begin
                c = step(c, bit_i);
                n++;
            end
            cyc(0, 0, 0, 0, insert_i, 0);
        end
        cyc(0, 0, 0, 0, 0, 0);
        r = c;
    endtask
endmodule

// File: sim/test_spi_crc_and_register_lock.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_spi_crc_and_register_lock;
    logic mclk_i = 0, rst_n_i = 0, rdrd = 0, en = 0, fmt = 0, pin_src = 1, cst = 0;
    logic wacc, ins, cbit, err, irq_n, sck, shf, sdn;
    logic [7:0]   key;
    logic [2:0]   stat;
    logic [15:0]  cks, cks_sck, rsd;
    logic [191:0] img = {12{16'h3c5a}};
    scl_pkg::scl_wr_req_t wr_req = '0;
    scl_pkg::scl_rd_evt_t evt;
    int err_count = 0, num_checks = 0, k;
    initial forever #25 mclk_i = ~mclk_i;
    scl_core i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .wr_req_i(wr_req),
        .wr_accept_o(wacc), .cfg_image_i(img), .conv_start_i(cst), .irq_reg_read_i(rdrd),
        .irq_pin_src_i(pin_src), .read_crc_enable_i(en), .crc_format_i(fmt),
        .write_lock_key_o(key), .config_map_checksum_o(cks), .config_crc_error_flag_o(err),
        .irq_n_o(irq_n), .sck_i(sck), .rd_evt_i(evt), .crc_shift_i(shf), .status_done_i(sdn),
        .data_ready_flag_i(1'b0), .por_flag_i(1'b0), .status_bits_o(stat), .crc_insert_o(ins),
        .crc_bit_o(cbit), .cfg_crc_sck_o(cks_sck));
    scl_host_model i_host (.sck_o(sck), .evt_o(evt), .shift_o(shf), .done_o(sdn),
        .insert_i(ins), .bit_i(cbit));
    function automatic logic [15:0] ref_crc(input logic [191:0] im, input logic [7:0] ky);
        logic [219:0] m;
        logic [15:0]  c;
        im = im | scl_pkg::IRQ_STAT_MASK;
        m = {4'h0, im[191:16], ky, im[15:0], 16'h0000};
        c = 16'h0000;
        for (int i = 219; i >= 0; i--) c = i_host.step(c, m[i]);
        return c;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic acc);
        @(negedge mclk_i) wr_req = '{valid: 1'b1, addr: a, data: d};
        #1 `CHK("accept", acc, wacc)
        @(negedge mclk_i) wr_req.valid = 1'b0;
    endtask
    task automatic irq_read();
        @(negedge mclk_i) rdrd = 1'b1;
        @(negedge mclk_i) rdrd = 1'b0;
    endtask
    task automatic t_lock();
        wr(4'h3, 8'h11, 1'b1);
        wr(4'hd, 8'h00, 1'b1);
        repeat (14) @(negedge mclk_i);
        `CHK("map crc", ref_crc(img, 8'h00), cks)
        repeat (11) @(negedge mclk_i);
        `CHK("irq quiet", 1'b1, irq_n)
        wr(4'h3, 8'h22, 1'b0);
    endtask
    task automatic t_error();
        img[100] = ~img[100];
        for (k = 0; k < 30 && irq_n !== 1'b0; k++) @(negedge mclk_i);
        `CHK("irq pin", 1'b0, irq_n)
        if (k == 30) test_done();
        // Pulse lands well before the next compare slot, so the clear is visible
        cst = 1'b1;
        @(negedge mclk_i) cst = 1'b0;
        @(negedge mclk_i);
        `CHK("irq pin", 1'b1, irq_n)
        for (k = 0; k < 30 && irq_n !== 1'b0; k++) @(negedge mclk_i);
        `CHK("irq pin", 1'b0, irq_n)
        if (k == 30) test_done();
        i_host.frame(1'b0, 4'h3, 16'h0000, k, rsd);
        `CHK("stat crc", 1'b1, stat[1])
        `CHK("sck crc", ref_crc(img, 8'h00), cks_sck)
        repeat (3) @(negedge mclk_i);
        irq_read();
        `CHK("irq flag", 1'b1, err)
        wr(4'hd, 8'ha5, 1'b1);
        repeat (2) @(negedge mclk_i);
        `CHK("irq pin", 1'b1, irq_n)
        `CHK("map crc", 16'h0000, cks)
        `CHK("irq flag", 1'b1, err)
        irq_read();
        @(negedge mclk_i);
        `CHK("irq flag", 1'b0, err)
    endtask
    task automatic t_read(input logic e, f, sm, input logic [3:0] a, input int nx);
        int n;
        logic [15:0] r, d, s;
        d = 16'h5ac3;
        s = 16'h0000;
        for (int i = 15; i >= 0; i--) s = i_host.step(s, d[i]);
        @(negedge mclk_i) en = e;
        fmt = f;
        repeat (3) @(negedge mclk_i);
        i_host.frame(sm, a, d, n, r);
        `CHK("crc bits", nx, n)
        `CHK("residue", (nx == 0) ? s : 16'h0000, r)
        `CHK("stat crc", 1'b0, stat[1])
    endtask
    initial begin
        // Link clock runs during reset so the serial side is reset too
        fork
            i_host.frame(1'b0, 4'h0, 16'h0000, k, rsd);
            repeat (20) @(negedge mclk_i);
        join
        rst_n_i = 1'b1;
        @(negedge mclk_i);
        `CHK("key", 8'ha5, key)
        `CHK("irq pin", 1'b1, irq_n)
        `CHK("map crc", 16'h0000, cks)
        t_lock();
        t_error();
        t_read(1'b0, 1'b0, 1'b1, 4'h3, 0);
        t_read(1'b1, 1'b0, 1'b1, 4'h3, 16);
        t_read(1'b1, 1'b0, 1'b0, 4'h3, 0);
        t_read(1'b1, 1'b0, 1'b0, 4'hf, 16);
        t_read(1'b1, 1'b1, 1'b1, 4'h7, 32);
        test_done();
    end
endmodule
